/* File: verilog/bsc_pkg.sv */
// package of constants and types for the boundary scan data register block
package bsc_pkg;
	// tap state codes as driven by the neighbouring tap controller
	typedef enum logic [3:0] {
		BSC_TLR = 4'h0,
		BSC_RTI = 4'h1,
		BSC_SEL_DR = 4'h2,
		BSC_CAP_DR = 4'h3,
		BSC_SHF_DR = 4'h4,
		BSC_EX1_DR = 4'h5,
		BSC_PAU_DR = 4'h6,
		BSC_EX2_DR = 4'h7,
		BSC_UPD_DR = 4'h8,
		BSC_SEL_IR = 4'h9,
		BSC_CAP_IR = 4'ha,
		BSC_SHF_IR = 4'hb,
		BSC_EX1_IR = 4'hc,
		BSC_PAU_IR = 4'hd,
		BSC_EX2_IR = 4'he,
		BSC_UPD_IR = 4'hf
	} bsc_tap_t;
	localparam int BSC_IR_W = 6;
	localparam logic [5:0] BSC_OP_EXTEST = 6'h00;
	localparam logic [5:0] BSC_OP_SAMPLE = 6'h01;
	localparam logic [5:0] BSC_OP_IDCODE = 6'h02;
	localparam logic [5:0] BSC_OP_HIGHZ = 6'h03;
	localparam logic [5:0] BSC_OP_CLAMP = 6'h3e;
	localparam logic [5:0] BSC_OP_BYPASS = 6'h3f;
	localparam logic BSC_BYPASS_CAPTURE = 1'b0;
	localparam logic BSC_CELL_RESET = 1'b0;
	localparam logic [31:0] BSC_IDCODE_RESET = 32'h00000001;
	localparam int BSC_N_IN = 4;
	localparam int BSC_N_OUT = 4;
	localparam int BSC_N_BIDI = 4;
endpackage : bsc_pkg

/* File: verilog/bsc_cell.sv */
// one boundary cell: capture/shift stage plus falling-edge update latch
`timescale 1ns/1ns
`default_nettype none
module bsc_cell
	import bsc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic tck_rise,
	input wire logic tck_fall,
	input wire logic capture,
	input wire logic shift,
	input wire logic update,
	input wire logic cap_in,
	input wire logic scan_in,
	output logic scan_out,
	output logic upd_out
);
	logic stage_q;
	logic upd_q;
	logic pend_q;
	assign scan_out = stage_q;
	assign upd_out = upd_q;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			stage_q <= BSC_CELL_RESET;
			upd_q <= BSC_CELL_RESET;
			pend_q <= 1'b0;
		end else if (clk_en) begin
			if (tck_rise && capture) begin
				stage_q <= cap_in;
			end else if (tck_rise && shift) begin
				stage_q <= scan_in;
			end
			if (tck_rise) begin
				pend_q <= update;
			end
			// update latch moves on the falling edge, away from capture skew
			if (tck_fall && pend_q) begin
				upd_q <= stage_q;
			end
		end
	end
endmodule : bsc_cell
`default_nettype wire

/* File: verilog/bsc_chain.sv */
// boundary scan test data registers, bypass and id register, serial output mux
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - input pins carry an observe cell, outputs carry control cells, bidirectional pins carry both.
// - there are three data registers: one-bit bypass, boundary scan and device id.
// - all data registers share one serial input and output, the instruction picks the output.
// - the boundary register sits in the path under EXTEST or SAMPLE/PRELOAD.
// - on entering EXTEST at Update-IR the held latch values drive pins and enables at once.
// - every boundary cell updates its latch on the falling test clock edge.
// - input cells only sample the pin and never drive anything.
// - enable cells match output cells but drive a pad enable instead of data.
// - each bidirectional pin has exactly an enable cell and a single capture cell.
// - outside EXTEST the core enable value selects the capture cell source.
// - enable high and no EXTEST captures core outgoing data.
// - enable low or EXTEST captures the pad incoming value.
// - scan input is taken on rising test clock, scan output changes on falling.
// - Capture-DR loads zero into the bypass bit.
module bsc_chain
	import bsc_pkg::*;
#(
	parameter int N_IN = BSC_N_IN,
	parameter int N_OUT = BSC_N_OUT,
	parameter int N_BIDI = BSC_N_BIDI,
	parameter logic [31:0] IDCODE_VAL = BSC_IDCODE_RESET // arbitrary value
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic tck,
	input wire logic tdi,
	input wire logic [3:0] tap_state,
	input wire logic [5:0] ir_code,
	input wire logic [N_IN-1:0] pin_in,
	input wire logic [N_OUT-1:0] core_out,
	input wire logic [N_OUT-1:0] core_oe,
	input wire logic [N_BIDI-1:0] core_bd_out,
	input wire logic [N_BIDI-1:0] core_bd_oe,
	input wire logic [N_BIDI-1:0] pad_bd_in,
	output logic tdo,
	output logic tdo_oe_n,
	output logic [N_OUT-1:0] pad_out,
	output logic [N_OUT-1:0] pad_oe,
	output logic [N_BIDI-1:0] pad_bd_out,
	output logic [N_BIDI-1:0] pad_bd_oe,
	output logic test_mode
);
	// ************************************************************
	// sampling of the external pins
	// ************************************************************
	localparam int NC = N_IN + 2 * N_OUT + 2 * N_BIDI;
	logic [1:0] tck_s_q, tdi_s_q;
	logic tck_d_q;
	logic [3:0] st_s1_q, st_s2_q;
	logic [5:0] ir_s1_q, ir_s2_q;
	logic [N_IN-1:0] pin_s1_q, pin_s2_q;
	logic [N_BIDI-1:0] bd_s1_q, bd_s2_q;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tck_s_q <= 2'h0;
			tdi_s_q <= 2'h0;
			tck_d_q <= 1'b0;
			st_s1_q <= 4'h0;
			st_s2_q <= 4'h0;
			ir_s1_q <= BSC_OP_BYPASS;
			ir_s2_q <= BSC_OP_BYPASS;
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			bd_s1_q <= '0;
			bd_s2_q <= '0;
		end else if (clk_en) begin
			tck_s_q <= {tck_s_q[0], tck};
			tdi_s_q <= {tdi_s_q[0], tdi};
			tck_d_q <= tck_s_q[1];
			st_s1_q <= tap_state;
			st_s2_q <= st_s1_q;
			ir_s1_q <= ir_code;
			ir_s2_q <= ir_s1_q;
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
			bd_s1_q <= pad_bd_in;
			bd_s2_q <= bd_s1_q;
		end
	end

	// ************************************************************
	// decode
	// ************************************************************
	wire tck_rise = tck_s_q[1] & ~tck_d_q;
	wire tck_fall = ~tck_s_q[1] & tck_d_q;
	wire st_cap = (st_s2_q == BSC_CAP_DR);
	wire st_shf = (st_s2_q == BSC_SHF_DR);
	wire st_upd = (st_s2_q == BSC_UPD_DR);
	wire ir_extest = (ir_s2_q == BSC_OP_EXTEST);
	wire ir_bsr = ir_extest | (ir_s2_q == BSC_OP_SAMPLE);
	wire ir_id = (ir_s2_q == BSC_OP_IDCODE);
	wire bsr_cap = st_cap & ir_bsr;
	wire bsr_shf = st_shf & ir_bsr;
	wire bsr_upd = st_upd & ir_bsr;

	// ************************************************************
	// boundary register: inputs, outputs (data+enable), bidi (enable+capture)
	// ************************************************************
	logic [NC-1:0] cap_v, upd_v;
	logic [NC:0] chain;
	assign chain[0] = tdi_s_q[1];
	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi++) begin : g_in
			assign cap_v[gi] = pin_s2_q[gi];
		end
		for (gi = 0; gi < N_OUT; gi++) begin : g_out
			assign cap_v[N_IN + 2 * gi] = core_out[gi];
			assign cap_v[N_IN + 2 * gi + 1] = core_oe[gi];
		end
		for (gi = 0; gi < N_BIDI; gi++) begin : g_bidi
			localparam int B = N_IN + 2 * N_OUT + 2 * gi;
			// enable cell, then single capture cell fed by the pad/core mux
			assign cap_v[B] = core_bd_oe[gi];
			assign cap_v[B + 1] = (core_bd_oe[gi] & ~ir_extest) ? core_bd_out[gi] : bd_s2_q[gi];
		end
		for (gi = 0; gi < NC; gi++) begin : g_cell
			bsc_cell u_cell (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.clk_en(clk_en),
				.tck_rise(tck_rise),
				.tck_fall(tck_fall),
				.capture(bsr_cap),
				.shift(bsr_shf),
				.update(bsr_upd),
				.cap_in(cap_v[gi]),
				.scan_in(chain[gi]),
				.scan_out(chain[gi + 1]),
				.upd_out(upd_v[gi])
			);
		end
	endgenerate

	// ************************************************************
	// bypass and id registers, output selection
	// ************************************************************
	logic byp_q;
	logic [31:0] id_q;
	logic tdo_q, tdo_oe_n_q;
	logic [N_OUT-1:0] pad_out_q, pad_oe_q;
	logic [N_BIDI-1:0] bd_out_q, bd_oe_q;
	logic test_q;
	wire sel_bit = ir_bsr ? chain[NC] : (ir_id ? id_q[0] : byp_q);
	// pins follow the update latches the moment extest is decoded; no wait for update-dr
	logic [N_OUT-1:0] upd_o, upd_oe;
	logic [N_BIDI-1:0] upd_bo, upd_boe;
	generate
		for (gi = 0; gi < N_OUT; gi++) begin : g_po
			assign upd_o[gi] = upd_v[N_IN + 2 * gi];
			assign upd_oe[gi] = upd_v[N_IN + 2 * gi + 1];
		end
		for (gi = 0; gi < N_BIDI; gi++) begin : g_pb
			assign upd_boe[gi] = upd_v[N_IN + 2 * N_OUT + 2 * gi];
			assign upd_bo[gi] = upd_v[N_IN + 2 * N_OUT + 2 * gi + 1];
		end
	endgenerate
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			byp_q <= BSC_BYPASS_CAPTURE;
			id_q <= BSC_IDCODE_RESET;
			tdo_q <= 1'b0;
			tdo_oe_n_q <= 1'b1;
			pad_out_q <= '0;
			pad_oe_q <= '0;
			bd_out_q <= '0;
			bd_oe_q <= '0;
			test_q <= 1'b0;
		end else if (clk_en) begin
			if (tck_rise && st_cap) begin
				byp_q <= BSC_BYPASS_CAPTURE;
				id_q <= IDCODE_VAL;
			end else if (tck_rise && st_shf) begin
				byp_q <= tdi_s_q[1];
				id_q <= {tdi_s_q[1], id_q[31:1]};
			end
			if (tck_fall) begin
				tdo_q <= sel_bit;
				tdo_oe_n_q <= ~st_shf;
			end
			test_q <= ir_extest;
			pad_out_q <= ir_extest ? upd_o : core_out;
			pad_oe_q <= ir_extest ? upd_oe : core_oe;
			bd_out_q <= ir_extest ? upd_bo : core_bd_out;
			bd_oe_q <= ir_extest ? upd_boe : core_bd_oe;
		end
	end
	assign tdo = tdo_q;
	assign tdo_oe_n = tdo_oe_n_q;
	assign pad_out = pad_out_q;
	assign pad_oe = pad_oe_q;
	assign pad_bd_out = bd_out_q;
	assign pad_bd_oe = bd_oe_q;
	assign test_mode = test_q;

	// ************************************************************
	// assertions
	// ************************************************************
	property p_byp_zero;
		@(posedge core_clk) disable iff (!reset_n)
		(clk_en && tck_rise && st_cap) |=> (byp_q == 1'b0);
	endproperty
	a_byp_zero: assert property (p_byp_zero) else $error("bypass not zero after capture");
	property p_extest_drive;
		@(posedge core_clk) disable iff (!reset_n)
		(clk_en && ir_extest) |=> (pad_out == $past(upd_o));
	endproperty
	a_extest_drive: assert property (p_extest_drive) else $error("extest pins not from latches");
	property p_extest_oe;
		@(posedge core_clk) disable iff (!reset_n)
		(clk_en && ir_extest) |=> (pad_oe == $past(upd_oe));
	endproperty
	a_extest_oe: assert property (p_extest_oe) else $error("extest enables not from latches");
	property p_tdo_fall;
		@(posedge core_clk) disable iff (!reset_n)
		(clk_en && !tck_fall) |=> $stable(tdo);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling edge");
	property p_tdo_sel;
		@(posedge core_clk) disable iff (!reset_n)
		(clk_en && tck_fall) |=> (tdo == $past(sel_bit));
	endproperty
	a_tdo_sel: assert property (p_tdo_sel) else $error("tdo not from selected register");
	property p_bsr_path;
		@(posedge core_clk) disable iff (!reset_n)
		(clk_en && tck_fall && ir_bsr) |=> (tdo == $past(chain[NC]));
	endproperty
	a_bsr_path: assert property (p_bsr_path) else $error("boundary register not in path");
	property p_bidi_ext;
		@(posedge core_clk) disable iff (!reset_n)
		(clk_en && tck_rise && bsr_cap && ir_extest) |=> (chain[NC] == $past(bd_s2_q[N_BIDI-1]));
	endproperty
	a_bidi_ext: assert property (p_bidi_ext) else $error("bidi capture not from pad in extest");
	property p_bidi_core;
		@(posedge core_clk) disable iff (!reset_n)
		// second to last bidi pin, its capture stage feeds chain[NC-2]
		(clk_en && tck_rise && bsr_cap && !ir_extest && core_bd_oe[N_BIDI-2])
			|=> (chain[NC-2] == $past(core_bd_out[N_BIDI-2]));
	endproperty
	a_bidi_core: assert property (p_bidi_core) else $error("bidi capture not from core");
	// last detected rise was in update-dr; state moves with the pin fall, so track the rise
	logic rise_upd_q;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rise_upd_q <= 1'b0;
		end else if (clk_en && tck_rise) begin
			rise_upd_q <= st_upd;
		end
	end
	property p_no_upd;
		@(posedge core_clk) disable iff (!reset_n)
		!(clk_en && tck_fall && rise_upd_q) |=> $stable(upd_v);
	endproperty
	a_no_upd: assert property (p_no_upd) else $error("latch moved outside update");
endmodule : bsc_chain
`default_nettype wire

/* File: tb/bsc_tester.sv */
// tester model: drives test clock, scan data, tap state and instruction
`timescale 1ns/1ns
`default_nettype none
module bsc_tester
	import bsc_pkg::*;
(
	input wire logic core_clk,
	input wire logic tdo,
	output logic tck,
	output logic tdi,
	output logic [3:0] tap_state,
	output logic [5:0] ir_code
);
	// ****************************************
	// tester beats
	// ****************************************
	// clock parked low outside frames, data line at its pull-up level
	initial begin
		tck = 1'b0;
		tdi = 1'b1;
		tap_state = BSC_TLR;
		ir_code = BSC_OP_BYPASS;
	end
	// inputs set while clock low, 4 cycles before rise; tdo read late in high phase
	task automatic beat(input bsc_tap_t st, input logic din, output logic dout);
		tap_state <= st;
		tdi <= din;
		repeat (4) @(posedge core_clk);
		tck <= 1'b1;
		repeat (4) @(posedge core_clk);
		dout = tdo;
		tck <= 1'b0;
	endtask : beat
	task automatic load_ir(input logic [5:0] op);
		logic d;
		ir_code <= op;
		beat(BSC_UPD_IR, 1'b1, d);
		beat(BSC_RTI, 1'b1, d);
	endtask : load_ir
	// upd low leaves the scan in pause, so the latches keep their old values
	task automatic dr_scan(input int n, input logic [63:0] vin, input logic upd, output logic [63:0] vout);
		logic d;
		vout = 64'h0;
		beat(BSC_CAP_DR, 1'b1, d);
		for (int k = 0; k < n; k++) begin
			beat(BSC_SHF_DR, vin[n-1-k], d);
			vout[n-1-k] = d;
		end
		beat(BSC_EX1_DR, 1'b1, d);
		beat(upd ? BSC_UPD_DR : BSC_PAU_DR, 1'b1, d);
		beat(BSC_RTI, 1'b1, d);
	endtask : dr_scan
endmodule : bsc_tester
`default_nettype wire

/* File: tb/tb_bsc_chain.sv */
// self-checking bench for the boundary scan data registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_bsc_chain
	import bsc_pkg::*;
();
	// ****************************************
	// bench
	// ****************************************
	localparam logic [31:0] ID_VAL = 32'h00000001; // arbitrary value
	logic core_clk, reset_n, tck, tdi, tdo, tdo_oe_n, test_mode;
	logic [3:0] tap_state, pin_in, core_out, core_oe, core_bd_out, core_bd_oe, pad_bd_in;
	logic [3:0] pad_out, pad_oe, pad_bd_out, pad_bd_oe;
	logic [5:0] ir_code;
	logic [63:0] got;
	logic [19:0] pre;
	int errors = 0;
	int check_count = 0;
	bsc_chain #(.N_IN(4), .N_OUT(4), .N_BIDI(4), .IDCODE_VAL(ID_VAL)) bsc_chain_inst (.core_clk(core_clk),
		.reset_n(reset_n), .clk_en(1'b1), .tck(tck), .tdi(tdi), .tap_state(tap_state), .ir_code(ir_code),
		.pin_in(pin_in), .core_out(core_out), .core_oe(core_oe), .core_bd_out(core_bd_out),
		.core_bd_oe(core_bd_oe), .pad_bd_in(pad_bd_in), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_bd_out(pad_bd_out), .pad_bd_oe(pad_bd_oe), .test_mode(test_mode));
	bsc_tester bsc_tester_inst (.core_clk(core_clk), .tdo(tdo), .tck(tck), .tdi(tdi), .tap_state(tap_state),
		.ir_code(ir_code));
	// chain order from scan input: inputs, output data/enable pairs, bidi enable/capture pairs
	function automatic logic [19:0] cap_exp(input logic ext);
		logic [19:0] c;
		c[3:0] = pin_in;
		for (int j = 0; j < 4; j++) begin
			c[4+2*j] = core_out[j];
			c[5+2*j] = core_oe[j];
			c[12+2*j] = core_bd_oe[j];
			c[13+2*j] = (core_bd_oe[j] && !ext) ? core_bd_out[j] : pad_bd_in[j];
		end
		return c;
	endfunction : cap_exp
	task automatic set_pins(input logic [23:0] p);
		{pin_in, core_out, core_oe, core_bd_out, core_bd_oe, pad_bd_in} <= p;
		repeat (4) @(posedge core_clk);
	endtask : set_pins
	task automatic chk_pads(input logic [19:0] v, input logic ext);
		for (int j = 0; j < 4; j++) begin
			`CHK(pad_out[j], ext ? v[4+2*j] : core_out[j])
			`CHK(pad_oe[j], ext ? v[5+2*j] : core_oe[j])
			`CHK(pad_bd_oe[j], ext ? v[12+2*j] : core_bd_oe[j])
			`CHK(pad_bd_out[j], ext ? v[13+2*j] : core_bd_out[j])
		end
		`CHK(test_mode, ext)
	endtask : chk_pads
	task automatic t_bypass();
		logic [5:0] ops[3] = '{BSC_OP_BYPASS, BSC_OP_CLAMP, BSC_OP_HIGHZ};
		for (int i = 0; i < 3; i++) begin
			bsc_tester_inst.load_ir(ops[i]);
			bsc_tester_inst.dr_scan(2, 64'h3, 1'b1, got);
			`CHK(got[1:0], 2'b01)
		end
		`CHK(tdo_oe_n, 1'b1)
	endtask : t_bypass
	task automatic t_idcode();
		logic [31:0] rev;
		bsc_tester_inst.load_ir(BSC_OP_IDCODE);
		bsc_tester_inst.dr_scan(32, 64'h0, 1'b1, got);
		// id leaves lsb first, so the first bit taken sits at the top of got
		for (int j = 0; j < 32; j++) begin
			rev[j] = got[31-j];
		end
		`CHK(rev, ID_VAL)
	endtask : t_idcode
	// mixed bidi enables cover both capture sources in one pass
	task automatic t_sample();
		pre = 20'h5a3c6;
		set_pins(24'ha53c69);
		bsc_tester_inst.load_ir(BSC_OP_SAMPLE);
		bsc_tester_inst.dr_scan(20, {44'h0, pre}, 1'b1, got); // safe preload
		`CHK(got[19:0], cap_exp(1'b0))
		chk_pads(pre, 1'b0);
	endtask : t_sample
	// output cell capture under extest is left open, so only inputs and bidi captures are compared
	task automatic t_extest();
		bsc_tester_inst.load_ir(BSC_OP_EXTEST);
		chk_pads(pre, 1'b1);
		set_pins(24'h5ac396);
		bsc_tester_inst.dr_scan(20, 64'hc3a5f, 1'b0, got);
		`CHK(got[19:0] & 20'haa00f, cap_exp(1'b1) & 20'haa00f)
		chk_pads(pre, 1'b1);
		bsc_tester_inst.dr_scan(20, 64'hc3a5f, 1'b1, got);
		chk_pads(20'hc3a5f, 1'b1);
		bsc_tester_inst.load_ir(BSC_OP_SAMPLE);
		chk_pads(20'h0, 1'b0);
	endtask : t_extest
	task automatic finish_test();
		if (errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		reset_n = 1'b0;
		{pin_in, core_out, core_oe, core_bd_out, core_bd_oe, pad_bd_in} = 24'h0;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_bypass();
		t_idcode();
		t_sample();
		t_extest();
		finish_test();
	end
	// about 1.1k core cycles of traffic expected
	initial begin
		#400000;
		errors++;
		finish_test();
	end
endmodule : tb_bsc_chain
`default_nettype wire
